// *** dv/cbu_branch_unit_sva.sv ***
// Assertions on the ports of the conditional branch unit.
`timescale 1ns/1ps
`default_nettype none
module cbu_branch_unit_sva #(
    parameter int PC_W = cbu_pkg::PC_WIDTH,
    parameter int OFF_W = cbu_pkg::OFFSET_WIDTH
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic insnValid,
    input wire logic [cbu_pkg::OP_WIDTH-1:0] branchOp,
    input wire logic [cbu_pkg::SELECT_WIDTH-1:0] flagSel,
    input wire logic [OFF_W-1:0] branchOffset,
    input wire logic [cbu_pkg::STATUS_WIDTH-1:0] statusRegister,
    input wire logic [PC_W-1:0] pcCurrent,
    input wire logic ready,
    input wire logic done,
    input wire logic taken,
    input wire logic [PC_W-1:0] pcNext,
    input wire logic statusWrite
);
    logic [PC_W-1:0] tgt;
    logic [PC_W-1:0] fall;
    wire acc = insnValid && ready;
    wire c = statusRegister[cbu_pkg::CARRY_BIT];
    wire z = statusRegister[cbu_pkg::ZERO_BIT];
    wire n = statusRegister[cbu_pkg::NEGATIVE_BIT];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Both targets are latched at acceptance, because the inputs may change before done.
    always_ff @(posedge sys_clk) begin
        if (acc) begin
            tgt <= pcCurrent + {{(PC_W-OFF_W){branchOffset[OFF_W-1]}}, branchOffset} + 1'b1;
            fall <= pcCurrent + 1'b1;
        end
    end
    sequence jump_s; ##1 !ready ##1 (done && taken && pcNext == tgt); endsequence
    sequence fall_s; ##1 (done && !taken && ready && pcNext == fall); endsequence
    property br_p(logic [cbu_pkg::OP_WIDTH-1:0] o, logic go);
        acc && branchOp == o |-> if (go) jump_s else fall_s;
    endproperty
    sel_clear_a: assert property (br_p(cbu_pkg::branch_on_selected_flag_clear, !statusRegister[flagSel]))
        else $error("selected flag branch wrong");
    equal_br_a: assert property (br_p(cbu_pkg::branch_on_equal, z)) else $error("equal branch wrong");
    not_equal_a: assert property (br_p(cbu_pkg::branch_on_not_equal, !z)) else $error("not equal branch wrong");
    carry_set_a: assert property (br_p(cbu_pkg::branch_on_carry_set, c)) else $error("carry set branch wrong");
    lower_br_a: assert property (br_p(cbu_pkg::branch_on_lower, c)) else $error("lower branch wrong");
    carry_clear_a: assert property (br_p(cbu_pkg::branch_on_carry_clear, !c)) else $error("carry clear wrong");
    same_high_a: assert property (br_p(cbu_pkg::branch_on_same_or_higher, !c)) else $error("same or higher wrong");
    minus_br_a: assert property (br_p(cbu_pkg::branch_on_minus, n)) else $error("minus branch wrong");
    plus_br_a: assert property (br_p(cbu_pkg::branch_on_plus, !n)) else $error("plus branch wrong");
    done_cause_a: assert property (done |-> $past(acc) || ($past(acc, 2) && !$past(ready)))
        else $error("done without a matching accept");
    no_flag_a: assert property (!statusWrite) else $error("flag write seen");
    ready_back_a: assert property (!ready |=> ready) else $error("ready low for more than one cycle");
    taken_done_a: assert property (taken |-> done) else $error("taken without done");
endmodule
bind cbu_branch_unit cbu_branch_unit_sva #(.PC_W(PC_W), .OFF_W(OFF_W)) cbu_branch_unit_sva_inst (
    .sys_clk(sys_clk), .rst(rst), .insnValid(insnValid), .branchOp(branchOp), .flagSel(flagSel),
    .branchOffset(branchOffset), .statusRegister(statusRegister), .pcCurrent(pcCurrent), .ready(ready),
    .done(done), .taken(taken), .pcNext(pcNext), .statusWrite(statusWrite));
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking testbench of the conditional branch unit.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic insnValid = 1'b0;
    logic [3:0] branchOp = 4'h0;
    logic [2:0] flagSel = 3'h0;
    logic [6:0] branchOffset = 7'h00;
    logic [7:0] statusRegister = 8'h00;
    logic [15:0] pcCurrent = 16'h0000;
    logic ready, done, taken, statusWrite;
    logic [15:0] pcNext;
    int err_count = 0;
    int comparisons = 0;
    always #20 sys_clk = ~sys_clk;
    cbu_branch_unit cbu_branch_unit_inst (.sys_clk(sys_clk), .rst(rst), .insnValid(insnValid),
        .branchOp(branchOp), .flagSel(flagSel), .branchOffset(branchOffset), .statusRegister(statusRegister),
        .pcCurrent(pcCurrent), .ready(ready), .done(done), .taken(taken), .pcNext(pcNext),
        .statusWrite(statusWrite));
    task automatic finish_test();
        $display("Mismatches %0d of %0d comparisons", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic expt(input logic [3:0] o, input logic [2:0] s, input logic [7:0] r);
        case (o)
            4'h0: return !r[s];
            4'h1: return r[1];
            4'h2: return !r[1];
            4'h3, 4'h6: return r[0];
            4'h4, 4'h5: return !r[0];
            4'h7: return r[2];
            4'h8: return !r[2];
            default: return 1'b0;
        endcase
    endfunction
    // Valid is left high on return, so the next call follows with no idle cycle, and after a taken
    // branch the old request still stands while ready is low, where it must be ignored.
    task automatic run(input logic [3:0] o, input logic [2:0] s, input logic [6:0] k, input logic [7:0] r,
        input logic [15:0] pc);
        int i;
        logic t;
        logic [15:0] e;
        t = expt(o, s, r);
        e = pc + 16'h0001 + (t ? {{9{k[6]}}, k} : 16'h0000);
        {branchOp, flagSel, branchOffset, statusRegister, pcCurrent} = {o, s, k, r, pc};
        insnValid = 1'b1;
        @(negedge sys_clk);
        chk({15'h0000, ready}, {15'h0000, !t});
        i = 0;
        while (done !== 1'b1 && i < 4) begin
            @(negedge sys_clk);
            i++;
        end
        if (i == 4) begin
            err_count++;
            finish_test();
        end else begin
            chk(16'(i), t ? 16'h0001 : 16'h0000);
            chk({15'h0000, taken}, {15'h0000, t});
            chk(pcNext, e);
            chk({15'h0000, statusWrite}, 16'h0000);
        end
    endtask
    initial begin
        void'($urandom(43245));
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        chk({12'h000, ready, done, taken, statusWrite}, 16'h0008);
        chk(pcNext, 16'h0000);
        run(4'h1, 3'h0, 7'h40, 8'h02, 16'h0000);
        run(4'h2, 3'h0, 7'h3F, 8'h00, 16'hFFFF);
        run(4'h0, 3'h7, 7'h01, 8'h7F, 16'h1234);
        run(4'h0, 3'h3, 7'h05, 8'h08, 16'h0100);
        run(4'h6, 3'h0, 7'h40, 8'h01, 16'h0000);
        run(4'hF, 3'h0, 7'h01, 8'hFF, 16'h0010);
        repeat (600) run(4'($urandom_range(15, 0)), 3'($urandom), 7'($urandom), 8'($urandom), 16'($urandom));
        insnValid = 1'b0;
        @(negedge sys_clk);
        chk({14'h0000, ready, done}, 16'h0002);
        finish_test();
    end
endmodule
`default_nettype wire

// *** logic/cbu_branch_unit.sv ***
// Sequencer of the conditional relative branches: condition test and program counter update.
`timescale 1ns/1ps
`default_nettype none
module cbu_branch_unit #(
    parameter int PC_W = cbu_pkg::PC_WIDTH,
    parameter int OFF_W = cbu_pkg::OFFSET_WIDTH
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic insnValid,
    input wire logic [cbu_pkg::OP_WIDTH-1:0] branchOp,
    input wire logic [cbu_pkg::SELECT_WIDTH-1:0] flagSel,
    input wire logic [OFF_W-1:0] branchOffset,
    input wire logic [cbu_pkg::STATUS_WIDTH-1:0] statusRegister,
    input wire logic [PC_W-1:0] pcCurrent,
    output logic ready,
    output logic done,
    output logic taken,
    output logic [PC_W-1:0] pcNext,
    output logic statusWrite
);
    cbu_cond_if cond ();

    cbu_cond_eval u_eval (
        .cond(cond)
    );

    assign cond.op = branchOp;
    assign cond.flagSel = flagSel;
    assign cond.statusRegister = statusRegister;

    cbu_pkg::cbu_state_e state;
    cbu_pkg::cbu_state_e next_state;
    logic next_ready;
    logic next_done;
    logic next_taken;
    logic [PC_W-1:0] next_pcNext;
    logic next_statusWrite;
    logic accept;
    logic jump;
    logic fallThrough;
    wire logic [PC_W-1:0] offsetExt;
    wire logic [PC_W-1:0] pcFall;
    wire logic [PC_W-1:0] pcTarget;
    wire logic [PC_W-1:0] targetHalf;
    wire logic [PC_W-1:0] fallCarry;
    wire logic [PC_W-1:0] targetCarry;

    // Both adders take a carry of one into bit 0, which supplies the plus one of the jump and of the fall-through.
    assign fallCarry[0] = 1'b1;
    assign targetCarry[0] = 1'b1;

    // The offset is two's complement, so every bit above its sign is a copy of the sign.
    // The carry out of the top bit is dropped, which is how a forward jump from a high address wraps.
    for (genvar b = 0; b < PC_W; b++) begin : g_bit
        if (b < OFF_W) begin : g_offset
            assign offsetExt[b] = branchOffset[b];
        end else begin : g_sign
            assign offsetExt[b] = branchOffset[OFF_W-1];
        end
        assign targetHalf[b] = pcCurrent[b] ^ offsetExt[b];
        assign pcFall[b] = pcCurrent[b] ^ fallCarry[b];
        assign pcTarget[b] = targetHalf[b] ^ targetCarry[b];
        if (b < PC_W - 1) begin : g_carry
            assign fallCarry[b+1] = pcCurrent[b] & fallCarry[b];
            assign targetCarry[b+1] = (pcCurrent[b] & offsetExt[b]) | (targetCarry[b] & targetHalf[b]);
        end
    end

    // Requests that arrive during the refill cycle are ignored, not queued.
    assign accept = insnValid && (state == cbu_pkg::CBU_IDLE);
    assign jump = accept && cond.met;
    assign fallThrough = accept && !cond.met;

    always_comb begin
        next_state = state;
        next_ready = ready;
        case (state)
            cbu_pkg::CBU_IDLE: begin
                if (jump) begin
                    // The second cycle stands for the refill of the fetch path after a jump.
                    next_state = cbu_pkg::CBU_TAKE;
                    next_ready = 1'b0;
                end
            end
            cbu_pkg::CBU_TAKE: begin
                next_state = cbu_pkg::CBU_IDLE;
                next_ready = 1'b1;
            end
            default: begin
                next_state = cbu_pkg::CBU_IDLE;
                next_ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= cbu_pkg::CBU_IDLE;
            ready <= cbu_pkg::RESET_READY;
        end else begin
            state <= next_state;
            ready <= next_ready;
        end
    end

    always_comb begin
        next_done = 1'b0;
        next_taken = 1'b0;
        case (state)
            cbu_pkg::CBU_IDLE: begin
                if (fallThrough) begin
                    next_done = 1'b1;
                    next_taken = 1'b0;
                end
            end
            cbu_pkg::CBU_TAKE: begin
                next_done = 1'b1;
                next_taken = 1'b1;
            end
            default: begin
                next_done = 1'b0;
                next_taken = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            done <= cbu_pkg::RESET_DONE;
            taken <= cbu_pkg::RESET_TAKEN;
        end else begin
            done <= next_done;
            taken <= next_taken;
        end
    end

    // The target is latched at acceptance, so on a taken branch pcNext leads done by one cycle.
    always_comb begin
        next_pcNext = pcNext;
        if (jump) begin
            next_pcNext = pcTarget;
        end else if (fallThrough) begin
            next_pcNext = pcFall;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pcNext <= PC_W'(cbu_pkg::RESET_PC);
        end else begin
            pcNext <= next_pcNext;
        end
    end

    // Branches never write a flag; the strobe is kept so the core sees a defined low level.
    always_comb begin
        next_statusWrite = 1'b0;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            statusWrite <= cbu_pkg::RESET_STATUS_WRITE;
        end else begin
            statusWrite <= next_statusWrite;
        end
    end
endmodule
`default_nettype wire

// *** logic/cbu_cond_eval.sv ***
// Condition evaluator: decides whether a branch is taken.
`timescale 1ns/1ps
`default_nettype none
module cbu_cond_eval (
    cbu_cond_if.eval cond
);
    logic carry;
    logic zero;
    logic negative;

    assign carry = cond.statusRegister[cbu_pkg::CARRY_BIT];
    assign zero = cond.statusRegister[cbu_pkg::ZERO_BIT];
    assign negative = cond.statusRegister[cbu_pkg::NEGATIVE_BIT];

    always_comb begin
        case (cond.op)
            cbu_pkg::branch_on_selected_flag_clear: cond.met = ~cond.statusRegister[cond.flagSel];
            cbu_pkg::branch_on_equal: cond.met = zero;
            cbu_pkg::branch_on_not_equal: cond.met = ~zero;
            cbu_pkg::branch_on_carry_set: cond.met = carry;
            cbu_pkg::branch_on_lower: cond.met = carry;
            cbu_pkg::branch_on_carry_clear: cond.met = ~carry;
            cbu_pkg::branch_on_same_or_higher: cond.met = ~carry;
            cbu_pkg::branch_on_minus: cond.met = negative;
            cbu_pkg::branch_on_plus: cond.met = ~negative;
            // Unassigned codes never branch, so a corrupt opcode simply falls through.
            default: cond.met = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// *** logic/cbu_cond_if.sv ***
// Carrier between the branch sequencer and the condition evaluator.
`timescale 1ns/1ps
`default_nettype none
interface cbu_cond_if;
    logic [cbu_pkg::OP_WIDTH-1:0] op;
    logic [cbu_pkg::SELECT_WIDTH-1:0] flagSel;
    logic [cbu_pkg::STATUS_WIDTH-1:0] statusRegister;
    logic met;

    modport core (output op, output flagSel, output statusRegister, input met);
    modport eval (input op, input flagSel, input statusRegister, output met);
endinterface
`default_nettype wire

// *** logic/cbu_pkg.sv ***
// Shared constants and types of the conditional branch unit.
package cbu_pkg;

    // Default widths of the program counter and of the signed offset, then widths of the status register, flag select and opcode.
    localparam int PC_WIDTH = 16;
    localparam int OFFSET_WIDTH = 7;
    localparam int STATUS_WIDTH = 8;
    localparam int SELECT_WIDTH = 3;
    localparam int OP_WIDTH = 4;

    // Bit positions of the flags inside the status register.
    localparam int CARRY_BIT = 0;
    localparam int ZERO_BIT = 1;
    localparam int NEGATIVE_BIT = 2;

    // Cycle counts of the two outcomes.
    localparam int CYCLES_NOT_TAKEN = 1;
    localparam int CYCLES_TAKEN = 2;

    // Values after reset.
    localparam logic RESET_READY = 1'b1;
    localparam logic RESET_DONE = 1'b0;
    localparam logic RESET_TAKEN = 1'b0;
    localparam logic [PC_WIDTH-1:0] RESET_PC = 16'h0000;
    localparam logic RESET_STATUS_WRITE = 1'b0;

    typedef enum logic [OP_WIDTH-1:0] {
        branch_on_selected_flag_clear,
        branch_on_equal,
        branch_on_not_equal,
        branch_on_carry_set,
        branch_on_carry_clear,
        branch_on_same_or_higher,
        branch_on_lower,
        branch_on_minus,
        branch_on_plus
    } cbu_op_e;

    typedef enum logic [0:0] {
        CBU_IDLE,
        CBU_TAKE
    } cbu_state_e;

endpackage
